// *** src/dubp_consts.svh ***
// Constants of the dual channel host bus port
// Operation
// - Three address bits pick a channel register
// - Eight bit two way data bus
// - Read strobe fall drives register byte out
// - Write strobe fall starts a write cycle
// - Write strobe rise latches bus byte
// - Channel A reached only while select low
// - Channel B reached only while select low
// - Bit three set: A irq driven, out2 low
// - Bit three clear: A irq floats, out2 high
// - Channel B same irq and out2 scheme
// - Channel A transmit ready, active low
// - Channel A receive ready, active low
// - Channel B transmit ready, active low
// - Channel B receive ready, active low
`ifndef DUBP_CONSTS_SVH
`define DUBP_CONSTS_SVH
`define DUBP_ADDR_W 3
`define DUBP_DATA_W 8
`define DUBP_NUM_REGS 8
`define DUBP_REG_RHR 3'h0
`define DUBP_REG_THR 3'h0
`define DUBP_REG_MCR 3'h4
`define DUBP_MCR_OUT2_BIT 3
`define DUBP_REG_RESET 8'h00
`define DUBP_SYNC_STAGES 3
`endif

// *** src/dubp_pkg.sv ***
// Types of the dual channel host bus port
package dubp_pkg;
    typedef enum logic [1:0] {DUBP_IDLE, DUBP_READ, DUBP_WRITE} dubp_state_t;
    typedef logic [7:0] dubp_byte_t;
endpackage

// *** src/dubp_chan_if.sv ***
// Link between bus port and channel register bank
`timescale 1ns/1ns
interface dubp_chan_if;
    logic wr_en;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic out2_en;
    modport port (output wr_en, output addr, output wdata, input rdata, input out2_en);
    modport bank (input wr_en, input addr, input wdata, output rdata, output out2_en);
endinterface

// *** src/dubp_chan_regs.sv ***
// Register bank of one serial channel
`timescale 1ns/1ns
`include "dubp_consts.svh"
module dubp_chan_regs
    import dubp_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] rx_byte_in,
    dubp_chan_if.bank bus
);
    logic [7:0] regs_ff [`DUBP_NUM_REGS];
    logic [7:0] nxt_regs [`DUBP_NUM_REGS];
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb
    begin
        for (int i = 0; i < `DUBP_NUM_REGS; i++)
        begin
            nxt_regs[i] = regs_ff[i];
        end
        if (bus.wr_en)
        begin
            nxt_regs[bus.addr] = bus.wdata;
        end
        // Receive data appears at the holding register address
        nxt_rdata = (bus.addr == `DUBP_REG_RHR) ? rx_byte_in : regs_ff[bus.addr];
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < `DUBP_NUM_REGS; i++)
            begin
                regs_ff[i] <= `DUBP_REG_RESET;
            end
            rdata_ff <= `DUBP_REG_RESET;
        end
        else
        begin
            regs_ff <= nxt_regs;
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus.rdata = rdata_ff;
    assign bus.out2_en = regs_ff[`DUBP_REG_MCR][`DUBP_MCR_OUT2_BIT];
endmodule

// *** src/dubp_host_port.sv ***
// Host bus port of a dual serial channel controller
`timescale 1ns/1ns
`include "dubp_consts.svh"
module dubp_host_port
    import dubp_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic reg_addr_bit2_in,
    input wire logic reg_addr_bit1_in,
    input wire logic reg_addr_bit0_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic chan_a_select_n_in,
    input wire logic chan_b_select_n_in,
    input wire logic chan_a_irq_src_in,
    input wire logic chan_b_irq_src_in,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe_n_out,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe_n_out,
    output logic chan_a_gp_out2_n_out,
    output logic chan_b_gp_out2_n_out,
    input wire logic chan_a_tx_ready_in,
    input wire logic chan_a_rx_ready_in,
    input wire logic chan_b_tx_ready_in,
    input wire logic chan_b_rx_ready_in,
    input wire logic [7:0] chan_a_rx_byte_in,
    input wire logic [7:0] chan_b_rx_byte_in,
    output logic chan_a_tx_ready_n_out,
    output logic chan_a_rx_ready_n_out,
    output logic chan_b_tx_ready_n_out,
    output logic chan_b_rx_ready_n_out
);
    localparam int SW = 6;
    logic [SW-1:0] sync1_ff, sync2_ff, sync3_ff;
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] nxt_stable;
    logic [SW-1:0] stable_ff;
    logic [2:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic [7:0] data_ff, nxt_data;
    logic oe_n_ff, nxt_oe_n;
    logic [1:0] sel_ff, nxt_sel;
    dubp_state_t state_ff, nxt_state;
    logic [1:0] wr_pulse;
    logic out2_a, out2_b;
    logic rd_n, wr_n, cs_a_n, cs_b_n;
    // Address and data pins, delayed one cycle less than the strobes
    logic [10:0] pin_bus;
    logic [10:0] bus_s1_ff, bus_s2_ff, bus_s3_ff;

    dubp_chan_if if_a ();
    dubp_chan_if if_b ();

    // Pin order: read, write, select A, select B, unused pair
    assign raw_pins = {2'h0, chan_b_select_n_in, chan_a_select_n_in,
        write_strobe_n_in, read_strobe_n_in};
    assign pin_bus = {reg_addr_bit2_in, reg_addr_bit1_in, reg_addr_bit0_in, data_in};

    always_comb
    begin
        for (int i = 0; i < SW; i++)
        begin
            nxt_stable[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : stable_ff[i];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            sync1_ff <= 6'h0F;
            sync2_ff <= 6'h0F;
            sync3_ff <= 6'h0F;
            stable_ff <= 6'h0F;
            bus_s1_ff <= 11'h000;
            bus_s2_ff <= 11'h000;
            bus_s3_ff <= 11'h000;
        end
        else
        begin
            sync1_ff <= raw_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            stable_ff <= nxt_stable;
            bus_s1_ff <= pin_bus;
            bus_s2_ff <= bus_s1_ff;
            bus_s3_ff <= bus_s2_ff;
        end
    end

    assign rd_n = stable_ff[0];
    assign wr_n = stable_ff[1];
    assign cs_a_n = stable_ff[2];
    assign cs_b_n = stable_ff[3];

    function automatic logic [1:0] chan_decode(input logic a_n, input logic b_n);
        chan_decode = {~b_n, ~a_n};
    endfunction

    always_comb
    begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_wdata = bus_s3_ff[7:0];
        nxt_data = data_ff;
        nxt_oe_n = 1'b1;
        nxt_sel = sel_ff;
        wr_pulse = 2'h0;
        case (state_ff)
            DUBP_IDLE:
            begin
                nxt_sel = chan_decode(cs_a_n, cs_b_n);
                nxt_addr = bus_s3_ff[10:8];
                if (!rd_n && (nxt_sel != 2'h0))
                begin
                    nxt_state = DUBP_READ;
                end
                else if (!wr_n && (nxt_sel != 2'h0))
                begin
                    nxt_state = DUBP_WRITE;
                end
            end
            DUBP_READ:
            begin
                nxt_data = sel_ff[0] ? if_a.rdata : if_b.rdata;
                nxt_oe_n = rd_n;
                if (rd_n)
                begin
                    nxt_state = DUBP_IDLE;
                end
            end
            DUBP_WRITE:
            begin
                nxt_wdata = wdata_ff;
                if (!wr_n)
                begin
                    nxt_wdata = bus_s3_ff[7:0];
                end
                else
                begin
                    wr_pulse = sel_ff;
                    nxt_state = DUBP_IDLE;
                end
            end
            default:
            begin
                nxt_state = DUBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= DUBP_IDLE;
            addr_ff <= 3'h0;
            wdata_ff <= 8'h00;
            data_ff <= 8'h00;
            oe_n_ff <= 1'b1;
            sel_ff <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            data_ff <= nxt_data;
            oe_n_ff <= nxt_oe_n;
            sel_ff <= nxt_sel;
        end
    end

    assign if_a.wr_en = wr_pulse[0];
    assign if_b.wr_en = wr_pulse[1];
    assign if_a.addr = addr_ff;
    assign if_b.addr = addr_ff;
    assign if_a.wdata = wdata_ff;
    assign if_b.wdata = wdata_ff;

    dubp_chan_regs u_regs_a (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .rx_byte_in(chan_a_rx_byte_in),
        .bus(if_a.bank)
    );

    dubp_chan_regs u_regs_b (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .rx_byte_in(chan_b_rx_byte_in),
        .bus(if_b.bank)
    );

    assign data_out = data_ff;
    assign data_oe_n_out = oe_n_ff;

    assign out2_a = if_a.out2_en;
    assign out2_b = if_b.out2_en;
    assign chan_a_irq_out = chan_a_irq_src_in;
    assign chan_a_irq_oe_n_out = ~out2_a;
    assign chan_a_gp_out2_n_out = ~out2_a;
    assign chan_b_irq_out = chan_b_irq_src_in;
    assign chan_b_irq_oe_n_out = ~out2_b;
    assign chan_b_gp_out2_n_out = ~out2_b;

    assign chan_a_tx_ready_n_out = ~chan_a_tx_ready_in;
    assign chan_a_rx_ready_n_out = ~chan_a_rx_ready_in;
    assign chan_b_tx_ready_n_out = ~chan_b_tx_ready_in;
    assign chan_b_rx_ready_n_out = ~chan_b_rx_ready_in;
endmodule

// *** testbench/dubp_host_port_chk.sv ***
// Assertion checker of the host bus port
`timescale 1ns/1ns
module dubp_host_port_chk (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic read_strobe_n_in,
    input wire logic chan_a_select_n_in,
    input wire logic chan_b_select_n_in,
    input wire logic data_oe_n_out,
    input wire logic chan_a_irq_src_in,
    input wire logic chan_a_irq_out,
    input wire logic chan_a_irq_oe_n_out,
    input wire logic chan_a_gp_out2_n_out,
    input wire logic chan_b_irq_oe_n_out,
    input wire logic chan_b_gp_out2_n_out,
    input wire logic chan_a_tx_ready_in,
    input wire logic chan_a_tx_ready_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_RST_OUT: assert property ($fell(sys_rst_in) |-> data_oe_n_out && chan_a_gp_out2_n_out)
        else $error("outputs not idle after reset");
    AST_RD_DRIVE: assert property ($fell(read_strobe_n_in) && !chan_a_select_n_in
        |-> ##[4:9] !data_oe_n_out) else $error("read not driven");
    AST_BUS_REL: assert property (read_strobe_n_in [*8] |-> data_oe_n_out)
        else $error("bus not released");
    AST_NO_SEL: assert property ($fell(read_strobe_n_in) && chan_a_select_n_in
        && chan_b_select_n_in |=> data_oe_n_out [*8]) else $error("unselected read");
    AST_OUT2_A: assert property (chan_a_gp_out2_n_out == chan_a_irq_oe_n_out)
        else $error("out2 a mismatch");
    AST_OUT2_B: assert property (chan_b_gp_out2_n_out == chan_b_irq_oe_n_out)
        else $error("out2 b mismatch");
    AST_IRQ_A: assert property (!chan_a_irq_oe_n_out |-> chan_a_irq_out == chan_a_irq_src_in)
        else $error("irq a wrong");
    AST_TXR_A: assert property (chan_a_tx_ready_n_out != chan_a_tx_ready_in)
        else $error("tx ready a wrong");
endmodule

// *** testbench/dubp_host_model.sv ***
// Host processor model on the parallel bus
`timescale 1ns/1ns
module dubp_host_model (
    input wire logic clk_in,
    input wire logic [7:0] data_bus_in,
    input wire logic data_oe_n_in,
    output logic [2:0] addr_out,
    output logic [7:0] data_drv_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [1:0] sel_n_out
);
    initial
    begin
        addr_out = 3'h0;
        data_drv_out = 8'h00;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        sel_n_out = 2'h3;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask
    task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
        sel_n_out = s;
        addr_out = a;
        data_drv_out = d;
        wr_n_out = 1'b0;
        step(10);
        wr_n_out = 1'b1;
        step(2);
        data_drv_out = ~d;
        sel_n_out = 2'h3;
        step(8);
    endtask
    task automatic rd(input logic [1:0] s, input logic [2:0] a, output logic [7:0] d);
        sel_n_out = s;
        addr_out = a;
        rd_n_out = 1'b0;
        step(10);
        // Released bus reads back as the inverse of the last driven byte
        d = data_oe_n_in ? ~data_bus_in : data_bus_in;
        rd_n_out = 1'b1;
        step(2);
        sel_n_out = 2'h3;
        step(8);
    endtask
endmodule

// *** testbench/dubp_host_port_bench.sv ***
// Testbench of the host bus port
`timescale 1ns/1ns
module dubp_host_port_bench;
    import dubp_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [2:0] ad;
    logic rd_n, wr_n, oe_n;
    logic [1:0] sel_n, irq, irq_oe_n, out2_n;
    logic [1:0] src = 2'h0;
    logic [3:0] st = 4'h0;
    logic [3:0] st_n;
    dubp_byte_t hd, dout, rb;
    int failures = 0;
    int n_compared = 0;
    dubp_host_port dubp_host_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_bit2_in(ad[2]), .reg_addr_bit1_in(ad[1]), .reg_addr_bit0_in(ad[0]),
        .data_in(hd), .data_out(dout), .data_oe_n_out(oe_n), .read_strobe_n_in(rd_n),
        .write_strobe_n_in(wr_n), .chan_a_select_n_in(sel_n[0]), .chan_b_select_n_in(sel_n[1]),
        .chan_a_irq_src_in(src[0]), .chan_b_irq_src_in(src[1]), .chan_a_irq_out(irq[0]),
        .chan_a_irq_oe_n_out(irq_oe_n[0]), .chan_b_irq_out(irq[1]),
        .chan_b_irq_oe_n_out(irq_oe_n[1]), .chan_a_gp_out2_n_out(out2_n[0]),
        .chan_b_gp_out2_n_out(out2_n[1]), .chan_a_tx_ready_in(st[0]), .chan_a_rx_ready_in(st[1]),
        .chan_b_tx_ready_in(st[2]), .chan_b_rx_ready_in(st[3]), .chan_a_rx_byte_in(8'h3C),
        .chan_b_rx_byte_in(8'hC3), .chan_a_tx_ready_n_out(st_n[0]),
        .chan_a_rx_ready_n_out(st_n[1]), .chan_b_tx_ready_n_out(st_n[2]),
        .chan_b_rx_ready_n_out(st_n[3]));
    dubp_host_model dubp_host_model_i (.clk_in(clk_in), .data_bus_in(dout), .data_oe_n_in(oe_n),
        .addr_out(ad), .data_drv_out(hd), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_n_out(sel_n));
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic end_sim;
        $display("failures %0d n_compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_regs;
        dubp_host_model_i.wr(2'h2, 3'h3, 8'hA5);
        dubp_host_model_i.wr(2'h1, 3'h3, 8'h5A);
        dubp_host_model_i.wr(2'h3, 3'h3, 8'hFF);
        dubp_host_model_i.wr(2'h2, 3'h7, 8'h81);
        dubp_host_model_i.rd(2'h3, 3'h3, rb);
        dubp_host_model_i.rd(2'h2, 3'h3, rb);
        chk("a reg3", 8'hA5, rb);
        dubp_host_model_i.rd(2'h1, 3'h3, rb);
        chk("b reg3", 8'h5A, rb);
        dubp_host_model_i.rd(2'h2, 3'h7, rb);
        chk("a reg7", 8'h81, rb);
        dubp_host_model_i.rd(2'h2, 3'h0, rb);
        chk("a rx", 8'h3C, rb);
        dubp_host_model_i.rd(2'h1, 3'h0, rb);
        chk("b rx", 8'hC3, rb);
    endtask
    task automatic t_mcr;
        chk("out2 rst", 8'h03, {6'h00, out2_n});
        chk("oe rst", 8'h07, {5'h00, oe_n, irq_oe_n});
        dubp_host_model_i.wr(2'h2, 3'h4, 8'h08);
        chk("out2 a on", 8'h02, {6'h00, out2_n});
        chk("irq oe a on", 8'h02, {6'h00, irq_oe_n});
        src = 2'h1;
        dubp_host_model_i.step(1);
        chk("irq a", 8'h01, {7'h00, irq[0]});
        dubp_host_model_i.wr(2'h1, 3'h4, 8'h08);
        chk("out2 b on", 8'h00, {6'h00, out2_n});
        dubp_host_model_i.wr(2'h2, 3'h4, 8'h00);
        chk("out2 a off", 8'h01, {6'h00, irq_oe_n & out2_n});
    endtask
    initial
    begin
        repeat (16) @(posedge clk_in);
        #5 sys_rst_in = 1'b0;
        dubp_host_model_i.step(4);
        t_mcr();
        t_regs();
        for (int i = 0; i < 4; i++)
        begin
            st = 4'h1 << i;
            dubp_host_model_i.step(1);
            chk("ready", {4'h0, ~st}, {4'h0, st_n});
        end
        end_sim();
    end
    initial
    begin
        #100000;
        failures++;
        end_sim();
    end
endmodule
bind dubp_host_port dubp_host_port_chk dubp_host_port_chk_i (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .read_strobe_n_in(read_strobe_n_in),
    .chan_a_select_n_in(chan_a_select_n_in),
    .chan_b_select_n_in(chan_b_select_n_in),
    .data_oe_n_out(data_oe_n_out),
    .chan_a_irq_src_in(chan_a_irq_src_in),
    .chan_a_irq_out(chan_a_irq_out),
    .chan_a_irq_oe_n_out(chan_a_irq_oe_n_out),
    .chan_a_gp_out2_n_out(chan_a_gp_out2_n_out),
    .chan_b_irq_oe_n_out(chan_b_irq_oe_n_out),
    .chan_b_gp_out2_n_out(chan_b_gp_out2_n_out),
    .chan_a_tx_ready_in(chan_a_tx_ready_in),
    .chan_a_tx_ready_n_out(chan_a_tx_ready_n_out)
);
